//--- tb/hsu_host_model.sv
/*
  host end of the serial link: sends frames into the port and samples its output.
  assumes tasks are called just after a rising clock edge.
*/
`timescale 1ns/1ps
module hsu_host_model (
  // clock
  input wire logic clk,
  // serial pins seen from the host
  input wire logic serial_out,
  output logic serial_in
);
  // ----------------------------------------
  // line driver and sampler
  // ----------------------------------------
  // data in, data out and ground only; no handshake lines
  initial serial_in = 1'b1;

  // bits leave lsb first; one idle bit after, so a low stop is seen to end
  task automatic send(input logic [11:0] b, input int n, input int bc);
    for (int i = 0; i < n; i++) begin
      serial_in <= b[i];
      repeat (bc) @(posedge clk);
    end
    serial_in <= 1'b1;
    repeat (bc) @(posedge clk);
  endtask

  task automatic get(output logic [11:0] b, input int n, input int bc);
    b = '1;
    while (serial_out !== 1'b0) @(posedge clk);
    repeat (bc / 2) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      b[i] = serial_out;
      repeat (bc) @(posedge clk);
    end
  endtask
endmodule // hsu_host_model

//--- tb/hsu_uart_properties.sv
/*
  concurrent checks on the ports of the host serial uart.
  assumes it is bound onto hsu_uart; one clock, reset_n async and active low.
*/
`timescale 1ns/1ps
module hsu_uart_properties (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // configuration and user side
  input wire hsu_pkg::hsu_cfg_t cfg,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_ready,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire hsu_pkg::hsu_err_t rx_err,
  input wire logic rx_take,
  // serial pins
  input wire logic serial_in,
  input wire logic serial_out
);
  // ----------------------------------------
  // transmit and receive relations
  // ----------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  // config must be steady, else the registered copy lags and the start may be masked
  sequence s_take;
    tx_valid && tx_ready && !cfg.loopback && $stable(cfg);
  endsequence
  sequence s_start_low;
    ##2 !serial_out;
  endsequence

  a_take_start_low: assert property (s_take |-> s_start_low) else $error("start bit late");
  a_take_drops_ready: assert property (tx_valid && tx_ready |=> !tx_ready) else $error("ready held");
  a_start_min_width: assert property ($fell(serial_out) |-> !serial_out [*8]) else $error("short bit");
  a_idle_line_high: assert property (tx_ready |-> serial_out) else $error("idle line low");
  a_stop_before_ready:
    assert property ($rose(tx_ready) |-> serial_out && $past(serial_out)) else $error("stop bit missing");
  a_loop_pin_high: assert property (cfg.loopback [*3] |=> serial_out) else $error("pin moves in loop");
  a_short_char_zero:
    assert property ($rose(rx_valid) && cfg.char_len == 2'h0 && $stable(cfg) |-> rx_data[7:5] == 3'h0)
    else $error("short char upper bits");
  a_break_framing:
    assert property ($rose(rx_valid) && rx_err.brk |-> rx_err.framing && rx_data == 8'h00)
    else $error("break without framing");
  a_take_clears: assert property (rx_take && rx_valid |=> !rx_valid) else $error("take ignored");
  a_no_parity_err:
    assert property ($rose(rx_valid) && cfg.parity == hsu_pkg::HSU_PAR_NONE && $stable(cfg) |-> !rx_err.parity)
    else $error("parity flag with parity off");
endmodule // hsu_uart_properties

bind hsu_uart hsu_uart_properties i_hsu_uart_properties (.clk(clk), .reset_n(reset_n), .cfg(cfg),
  .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data),
  .rx_err(rx_err), .rx_take(rx_take), .serial_in(serial_in), .serial_out(serial_out));

//--- tb/hsu_uart_tb_top.sv
/*
  self-checking bench for the host serial uart with a host line model.
  assumes the checker is bound in; most traffic runs at the fastest rate to keep the run short.
*/
`timescale 1ns/1ps
module hsu_uart_tb_top;
  localparam int BC = 16 * ((100000000 + 921600 * 8) / (921600 * 16));
  logic clk, reset_n, tx_valid, tx_ready, rx_valid, rx_take, serial_in, serial_out;
  logic [7:0] tx_data, rx_data;
  hsu_pkg::hsu_cfg_t cfg;
  hsu_pkg::hsu_err_t rx_err;
  int fails, num_checks, cyc;

  hsu_uart i_hsu_uart (.clk(clk), .reset_n(reset_n), .cfg(cfg), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data), .rx_err(rx_err), .rx_take(rx_take),
    .serial_in(serial_in), .serial_out(serial_out));
  hsu_host_model i_hsu_host_model (.clk(clk), .serial_out(serial_out), .serial_in(serial_in));

  // ----------------------------------------
  // clock, timeout and helpers
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      fails = fails + 1;
      finish_test();
    end
  end

  task automatic finish_test();
    if (fails == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic do_reset(input hsu_pkg::hsu_cfg_t c);
    reset_n <= 1'b0;
    cfg <= c;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    repeat (5) @(posedge clk);
    chk("out rx ready", 12'h5, {9'h0, serial_out, rx_valid, tx_ready});
  endtask

  task automatic dut_tx(input logic [7:0] d);
    tx_valid <= 1'b1;
    tx_data <= d;
    do @(posedge clk); while (tx_ready !== 1'b1);
    tx_valid <= 1'b0;
  endtask

  task automatic take_rx(input logic [7:0] d, input logic [3:0] e);
    int k;
    k = 0;
    while (rx_valid !== 1'b1 && k < 16 * BC) begin
      @(posedge clk);
      k++;
    end
    chk("rx data", {4'h0, d}, {4'h0, rx_data});
    chk("rx err", {8'h0, e}, {8'h0, rx_err});
    rx_take <= 1'b1;
    @(posedge clk);
    rx_take <= 1'b0;
  endtask

  // start, nb data bits, optional parity, stop bits left at one
  function automatic logic [11:0] frame(input logic [7:0] d, input int nb, input int par);
    logic [11:0] f;
    logic p;
    f = '1;
    f[0] = 1'b0;
    for (int i = 0; i < nb; i++) begin
      f[i + 1] = d[i];
    end
    p = ^(d & 8'((1 << nb) - 1));
    if (par != 0) f[nb + 1] = (par == 1) ? p : (par == 2) ? ~p : (par == 3);
    return f;
  endfunction

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    logic [11:0] got;
    logic [7:0] d, r;
    int nb, par, two, n, w, div;
    int rates [9];
    hsu_pkg::hsu_cfg_t c;
    // indexed by rate code, so every decoded rate is measured once
    rates = '{9600, 19200, 57600, 115200, 4800, 38400, 230400, 460800, 921600};
    reset_n = 1'b0;
    cfg = hsu_pkg::CFG_RESET;
    tx_valid = 1'b0;
    tx_data = 8'h00;
    rx_take = 1'b0;
    fails = 0;
    num_checks = 0;
    cyc = 0;
    void'($urandom(32'h2bd1a2cf));
    // each rate is cut short by a reset once its start bit is measured
    for (int j = 0; j < 9; j++) begin
      c = hsu_pkg::CFG_RESET;
      c.rate = hsu_pkg::hsu_rate_t'(j);
      do_reset(c);
      div = (100000000 + rates[j] * 8) / (rates[j] * 16);
      dut_tx(8'h01);
      while (serial_out !== 1'b0) @(posedge clk);
      w = 0;
      while (serial_out === 1'b0) begin
        @(posedge clk);
        w++;
      end
      chk("start width", 12'h1, {11'h0, w > 15 * div - 3 && w < 16 * div + 3});
    end
    do_reset(hsu_pkg::CFG_RESET);
    for (int t = 0; t < 10; t++) begin
      par = t % 5;
      nb = 5 + (t % 4);
      two = $urandom_range(1);
      d = 8'($urandom);
      r = 8'($urandom);
      cfg <= '{rate: hsu_pkg::HSU_RATE_921600, parity: hsu_pkg::hsu_parity_t'(par), two_stop: two[0],
               char_len: 2'(nb - 5), loopback: 1'b0};
      repeat (2) @(posedge clk);
      n = nb + 2 + (par != 0) + two;
      fork
        begin
          dut_tx(d);
          repeat (2) @(posedge clk);
          w = 2;
          while (tx_ready !== 1'b1) begin
            @(posedge clk);
            w++;
          end
        end
        i_hsu_host_model.get(got, n, BC);
        i_hsu_host_model.send(frame(r, nb, par), n - two, BC);
      join
      chk("tx frame", frame(d, nb, par) & 12'((1 << n) - 1), got & 12'((1 << n) - 1));
      chk("tx length", 12'(n), 12'((w + BC / 2) / BC));
      take_rx(r & 8'((1 << nb) - 1), 4'h0);
    end
    cfg <= '{rate: hsu_pkg::HSU_RATE_921600, parity: hsu_pkg::HSU_PAR_EVEN, two_stop: 1'b0,
             char_len: hsu_pkg::LEN_8, loopback: 1'b0};
    repeat (2) @(posedge clk);
    i_hsu_host_model.send(frame(8'h5a, 8, 1) ^ 12'h200, 11, BC);
    take_rx(8'h5a, 4'h4);
    i_hsu_host_model.send(frame(8'h5a, 8, 1) ^ 12'h400, 11, BC);
    take_rx(8'h5a, 4'h8);
    i_hsu_host_model.send(12'h000, 11, BC);
    take_rx(8'h00, 4'h9);
    i_hsu_host_model.send(frame(8'h11, 8, 1), 11, BC);
    i_hsu_host_model.send(frame(8'h22, 8, 1), 11, BC);
    take_rx(8'h22, 4'h2);
    // a low pulse shorter than half a bit must not start a character
    i_hsu_host_model.send(12'h000, 1, BC / 4);
    repeat (12 * BC) @(posedge clk);
    chk("glitch rx", 12'h0, {11'h0, rx_valid});
    cfg.loopback <= 1'b1;
    repeat (2) @(posedge clk);
    dut_tx(8'hc3);
    take_rx(8'hc3, 4'h0);
    chk("loop pin", 12'h1, {11'h0, serial_out});
    finish_test();
  end
endmodule // hsu_uart_tb_top

//--- verilog/hsu_pkg.sv
/*
  package for the host serial uart: configuration encodings, frame layout, rate table.
  assumes a 100 mhz system clock and 16x oversampling of the serial line.
*/
package hsu_pkg;

  // ----------------------------------------
  // clock and oversampling
  // ----------------------------------------
  localparam int unsigned CLK_HZ = 100000000;
  localparam int unsigned OVERSAMPLE = 16;
  localparam logic [3:0] MID_TICK = 4'h7;
  localparam logic [3:0] LAST_TICK = 4'hf;

  // ----------------------------------------
  // line rates in bits per second
  // ----------------------------------------
  localparam int unsigned BAUD_4800 = 4800;
  localparam int unsigned BAUD_9600 = 9600;
  localparam int unsigned BAUD_19200 = 19200;
  localparam int unsigned BAUD_38400 = 38400;
  localparam int unsigned BAUD_57600 = 57600;
  localparam int unsigned BAUD_115200 = 115200;
  localparam int unsigned BAUD_230400 = 230400;
  localparam int unsigned BAUD_460800 = 460800;
  localparam int unsigned BAUD_921600 = 921600;

  // divider per oversample tick, rounded to nearest
  function automatic logic [11:0] tick_div(input int unsigned baud);
    tick_div = 12'((CLK_HZ + (baud * OVERSAMPLE) / 2) / (baud * OVERSAMPLE));
  endfunction

  // rate select codes; code 0 is the stored default
  typedef enum logic [3:0] {
    HSU_RATE_9600   = 4'h0,
    HSU_RATE_19200  = 4'h1,
    HSU_RATE_57600  = 4'h2,
    HSU_RATE_115200 = 4'h3,
    HSU_RATE_4800   = 4'h4,
    HSU_RATE_38400  = 4'h5,
    HSU_RATE_230400 = 4'h6,
    HSU_RATE_460800 = 4'h7,
    HSU_RATE_921600 = 4'h8
  } hsu_rate_t;

  localparam hsu_rate_t RATE_RESET = HSU_RATE_9600;

  typedef enum logic [2:0] {
    HSU_PAR_NONE = 3'h0,
    HSU_PAR_EVEN = 3'h1,
    HSU_PAR_ODD  = 3'h2,
    HSU_PAR_ONE  = 3'h3,
    HSU_PAR_ZERO = 3'h4
  } hsu_parity_t;

  // character length code: data bits = code + 5
  localparam logic [1:0] LEN_8 = 2'h3;
  localparam logic [3:0] LEN_BASE = 4'h5;

  typedef struct packed {
    hsu_rate_t rate;
    hsu_parity_t parity;
    logic two_stop;
    logic [1:0] char_len;
    logic loopback;
  } hsu_cfg_t;

  localparam hsu_cfg_t CFG_RESET = '{rate: HSU_RATE_9600, parity: HSU_PAR_NONE,
                                     two_stop: 1'b0, char_len: LEN_8, loopback: 1'b0};

  typedef struct packed {
    logic framing;
    logic parity;
    logic overrun;
    logic brk;
  } hsu_err_t;

  typedef enum logic [2:0] {
    HSU_ST_IDLE   = 3'h0,
    HSU_ST_START  = 3'h1,
    HSU_ST_DATA   = 3'h2,
    HSU_ST_PARITY = 3'h3,
    HSU_ST_STOP   = 3'h4,
    HSU_ST_STOP2  = 3'h5
  } hsu_state_t;

endpackage

//--- verilog/hsu_tick_gen.sv
/*
  oversample tick generator for the host serial uart.
  assumes rate code comes from the same clock domain; a change does not restart the count.
*/
`timescale 1ns/1ps
module hsu_tick_gen (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // rate select
  input wire hsu_pkg::hsu_rate_t rate,
  // one pulse per sixteenth of a bit
  output logic tick
);

  // ----------------------------------------
  // rate table
  // ----------------------------------------
  logic [11:0] div;
  logic [11:0] cnt_ff;
  logic [11:0] nxt_cnt;

  always_comb begin
    unique case (rate)
      hsu_pkg::HSU_RATE_9600: div = hsu_pkg::tick_div(hsu_pkg::BAUD_9600);
      hsu_pkg::HSU_RATE_19200: div = hsu_pkg::tick_div(hsu_pkg::BAUD_19200);
      hsu_pkg::HSU_RATE_57600: div = hsu_pkg::tick_div(hsu_pkg::BAUD_57600);
      hsu_pkg::HSU_RATE_115200: div = hsu_pkg::tick_div(hsu_pkg::BAUD_115200);
      hsu_pkg::HSU_RATE_4800: div = hsu_pkg::tick_div(hsu_pkg::BAUD_4800);
      hsu_pkg::HSU_RATE_38400: div = hsu_pkg::tick_div(hsu_pkg::BAUD_38400);
      hsu_pkg::HSU_RATE_230400: div = hsu_pkg::tick_div(hsu_pkg::BAUD_230400);
      hsu_pkg::HSU_RATE_460800: div = hsu_pkg::tick_div(hsu_pkg::BAUD_460800);
      hsu_pkg::HSU_RATE_921600: div = hsu_pkg::tick_div(hsu_pkg::BAUD_921600);
      // unused codes fall back to the default rate
      default: div = hsu_pkg::tick_div(hsu_pkg::BAUD_9600);
    endcase
  end

  // ----------------------------------------
  // divider
  // ----------------------------------------
  assign nxt_cnt = (cnt_ff >= div - 12'h001) ? 12'h000 : cnt_ff + 12'h001;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= 12'h000;
      tick <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      tick <= (nxt_cnt == 12'h000);
    end
  end

endmodule // hsu_tick_gen

//--- verilog/hsu_uart.sv
/*
  host serial uart: full duplex transmitter and receiver with parity, stop bits,
  character length, line error flags and loopback.
  assumes configuration is static while frames are in flight; the serial input is asynchronous.
*/
// Notes on behaviour
// RULE1: transmit and receive run independently, simultaneously
// RULE2: default frame 8n1, lsb first
// RULE3: rate chosen from stored rate codes
// RULE4: rate defaults to 9600 after reset
// RULE5: only serial in and out, no handshake
// RULE6: parity even, odd, one, zero, or none
// RULE7: one or two stop bits transmitted
// RULE8: five to eight data bits both ways
// RULE9: rates 4.8 to 921.6 kbps programmable
// RULE10: stop bit sampled low flags framing error
// RULE11: flag overrun, parity mismatch and break
// RULE12: loopback feeds tx to rx, pin idles high
// RULE13: start edge, mid-bit confirm, centre sampling
`timescale 1ns/1ps
module hsu_uart (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // configuration
  input wire hsu_pkg::hsu_cfg_t cfg,
  // transmit side
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready,
  // receive side
  output logic rx_valid,
  output logic [7:0] rx_data,
  output hsu_pkg::hsu_err_t rx_err,
  input wire logic rx_take,
  // serial pins
  input wire logic serial_in,
  output logic serial_out
);

  // ----------------------------------------
  // reset release and input synchroniser
  // ----------------------------------------
  logic rst_meta_ff;
  logic rst_n_ff;
  logic rx_meta_ff;
  logic rx_sync_ff;
  logic tick;
  hsu_pkg::hsu_cfg_t cfg_ff;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_ff <= 1'b0;
      rst_n_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_n_ff <= rst_meta_ff;
    end
  end

  always_ff @(posedge clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      rx_meta_ff <= 1'b1;
      rx_sync_ff <= 1'b1;
    end else begin
      rx_meta_ff <= serial_in; // RULE5
      rx_sync_ff <= rx_meta_ff;
    end
  end

  // configuration registered; reset value is 9600 8n1
  always_ff @(posedge clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      cfg_ff <= hsu_pkg::CFG_RESET; // RULE2 RULE4
    end else begin
      cfg_ff <= cfg;
    end
  end

  hsu_tick_gen i_hsu_tick_gen (
    .clk(clk),
    .rst_n(rst_n_ff),
    .rate(cfg_ff.rate), // RULE3 RULE9
    .tick(tick)
  );

  logic [3:0] nbits;
  assign nbits = hsu_pkg::LEN_BASE + {2'h0, cfg_ff.char_len}; // RULE8

  // parity bit for a character: even-style xor, then per mode
  function automatic logic par_bit(input logic [7:0] d, input logic [1:0] len, input hsu_pkg::hsu_parity_t p);
    logic x;
    logic [7:0] m;
    m = 8'hff >> (3'h3 - {1'b0, len});
    x = ^(d & m);
    unique case (p)
      hsu_pkg::HSU_PAR_EVEN: par_bit = x;
      hsu_pkg::HSU_PAR_ODD: par_bit = ~x;
      hsu_pkg::HSU_PAR_ONE: par_bit = 1'b1;
      default: par_bit = 1'b0;
    endcase
  endfunction

  // ----------------------------------------
  // transmitter
  // ----------------------------------------
  hsu_pkg::hsu_state_t tx_st_ff;
  logic [3:0] tx_tick_ff;
  logic [3:0] tx_bit_ff;
  logic [7:0] tx_sh_ff;
  logic tx_par_ff;
  logic tx_line_ff;
  logic tx_end;

  assign tx_end = tick && tx_tick_ff == hsu_pkg::LAST_TICK;

  // independent of the receiver, so both directions run at once
  always_ff @(posedge clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      tx_st_ff <= hsu_pkg::HSU_ST_IDLE;
      tx_tick_ff <= 4'h0;
      tx_bit_ff <= 4'h0;
      tx_sh_ff <= 8'h00;
      tx_par_ff <= 1'b0;
      tx_line_ff <= 1'b1;
      tx_ready <= 1'b0;
    end else begin
      if (tick) begin
        tx_tick_ff <= tx_tick_ff + 4'h1;
      end
      unique case (tx_st_ff)
        hsu_pkg::HSU_ST_IDLE: begin
          tx_line_ff <= 1'b1;
          tx_ready <= 1'b1;
          if (tx_valid && tx_ready) begin // RULE1
            tx_ready <= 1'b0;
            tx_sh_ff <= tx_data;
            tx_par_ff <= par_bit(tx_data, cfg_ff.char_len, cfg_ff.parity); // RULE6
            tx_tick_ff <= 4'h0;
            tx_line_ff <= 1'b0;
            tx_st_ff <= hsu_pkg::HSU_ST_START;
          end
        end
        hsu_pkg::HSU_ST_START: if (tx_end) begin
          tx_line_ff <= tx_sh_ff[0]; // RULE2
          tx_sh_ff <= {1'b0, tx_sh_ff[7:1]};
          tx_bit_ff <= 4'h1;
          tx_st_ff <= hsu_pkg::HSU_ST_DATA;
        end
        hsu_pkg::HSU_ST_DATA: if (tx_end) begin
          if (tx_bit_ff == nbits) begin // RULE8
            if (cfg_ff.parity != hsu_pkg::HSU_PAR_NONE) begin
              tx_line_ff <= tx_par_ff;
              tx_st_ff <= hsu_pkg::HSU_ST_PARITY;
            end else begin
              tx_line_ff <= 1'b1;
              tx_st_ff <= hsu_pkg::HSU_ST_STOP;
            end
          end else begin
            tx_line_ff <= tx_sh_ff[0];
            tx_sh_ff <= {1'b0, tx_sh_ff[7:1]};
            tx_bit_ff <= tx_bit_ff + 4'h1;
          end
        end
        hsu_pkg::HSU_ST_PARITY: if (tx_end) begin
          tx_line_ff <= 1'b1;
          tx_st_ff <= hsu_pkg::HSU_ST_STOP;
        end
        hsu_pkg::HSU_ST_STOP: if (tx_end) begin
          tx_st_ff <= cfg_ff.two_stop ? hsu_pkg::HSU_ST_STOP2 : hsu_pkg::HSU_ST_IDLE; // RULE7
        end
        hsu_pkg::HSU_ST_STOP2: if (tx_end) begin
          tx_st_ff <= hsu_pkg::HSU_ST_IDLE;
        end
        default: tx_st_ff <= hsu_pkg::HSU_ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // pin and loopback
  // ----------------------------------------
  logic rx_line;
  assign rx_line = cfg_ff.loopback ? tx_line_ff : rx_sync_ff; // RULE12

  always_ff @(posedge clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      serial_out <= 1'b1;
    end else begin
      serial_out <= cfg_ff.loopback ? 1'b1 : tx_line_ff; // RULE12
    end
  end

  // ----------------------------------------
  // receiver
  // ----------------------------------------
  hsu_pkg::hsu_state_t rx_st_ff;
  logic [3:0] rx_tick_ff;
  logic [3:0] rx_bit_ff;
  logic [7:0] rx_sh_ff;
  logic rx_par_ff;
  logic rx_any_ff;
  logic rx_prev_ff;
  logic rx_mid;
  logic rx_done;
  logic [7:0] rx_word;

  assign rx_mid = tick && rx_tick_ff == hsu_pkg::MID_TICK;
  // data is shifted in from the top; align to bit 0 for short characters
  assign rx_word = rx_sh_ff >> (3'h3 - {1'b0, cfg_ff.char_len});

  always_ff @(posedge clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      rx_st_ff <= hsu_pkg::HSU_ST_IDLE;
      rx_tick_ff <= 4'h0;
      rx_bit_ff <= 4'h0;
      rx_sh_ff <= 8'h00;
      rx_par_ff <= 1'b0;
      rx_any_ff <= 1'b0;
      rx_prev_ff <= 1'b1;
      rx_done <= 1'b0;
    end else begin
      rx_prev_ff <= rx_line;
      rx_done <= 1'b0;
      if (tick) begin
        rx_tick_ff <= rx_tick_ff + 4'h1;
      end
      unique case (rx_st_ff)
        hsu_pkg::HSU_ST_IDLE: if (rx_prev_ff && !rx_line) begin // RULE13
          rx_tick_ff <= 4'h0;
          rx_st_ff <= hsu_pkg::HSU_ST_START;
        end
        hsu_pkg::HSU_ST_START: if (rx_mid) begin
          // a glitch shorter than half a bit is dropped
          if (rx_line) begin
            rx_st_ff <= hsu_pkg::HSU_ST_IDLE; // RULE13
          end else begin
            rx_tick_ff <= hsu_pkg::MID_TICK + 4'h1; // realign to centre
            rx_bit_ff <= 4'h0;
            rx_any_ff <= 1'b0;
            rx_st_ff <= hsu_pkg::HSU_ST_DATA;
          end
        end
        hsu_pkg::HSU_ST_DATA: if (rx_mid) begin
          rx_sh_ff <= {rx_line, rx_sh_ff[7:1]}; // RULE13
          rx_any_ff <= rx_any_ff | rx_line;
          rx_bit_ff <= rx_bit_ff + 4'h1;
          if (rx_bit_ff + 4'h1 == nbits) begin // RULE8
            rx_st_ff <= (cfg_ff.parity != hsu_pkg::HSU_PAR_NONE) ? hsu_pkg::HSU_ST_PARITY : hsu_pkg::HSU_ST_STOP;
          end
        end
        hsu_pkg::HSU_ST_PARITY: if (rx_mid) begin
          rx_par_ff <= rx_line;
          rx_any_ff <= rx_any_ff | rx_line;
          rx_st_ff <= hsu_pkg::HSU_ST_STOP;
        end
        hsu_pkg::HSU_ST_STOP: if (rx_mid) begin
          // receiver needs only one stop bit; a second one is idle line
          rx_done <= 1'b1;
          rx_prev_ff <= 1'b0; // no new start until the line returns high
          rx_any_ff <= rx_any_ff | rx_line;
          rx_sh_ff <= rx_sh_ff;
          rx_par_ff <= rx_par_ff;
          rx_st_ff <= hsu_pkg::HSU_ST_IDLE;
        end
        default: rx_st_ff <= hsu_pkg::HSU_ST_IDLE;
      endcase
    end
  end

  // stop bit value captured with rx_done
  logic rx_stop_ff;
  always_ff @(posedge clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      rx_stop_ff <= 1'b1;
    end else if (rx_st_ff == hsu_pkg::HSU_ST_STOP && rx_mid) begin
      rx_stop_ff <= rx_line;
    end
  end

  // ----------------------------------------
  // holding register and error flags
  // ----------------------------------------
  // a new character sets the flags, and wins over a take in the same cycle
  always_ff @(posedge clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      rx_valid <= 1'b0;
      rx_data <= 8'h00;
      rx_err <= '0;
    end else if (rx_done) begin
      rx_valid <= 1'b1;
      rx_data <= rx_word;
      rx_err.framing <= !rx_stop_ff; // RULE10
      rx_err.parity <= (cfg_ff.parity != hsu_pkg::HSU_PAR_NONE) &&
                       (rx_par_ff != par_bit(rx_word, cfg_ff.char_len, cfg_ff.parity)); // RULE11
      rx_err.brk <= !rx_any_ff && !rx_stop_ff; // RULE11
      rx_err.overrun <= rx_valid && !rx_take; // RULE11
    end else if (rx_take) begin
      rx_valid <= 1'b0;
    end
  end

endmodule // hsu_uart
